/* tb_wheel_sensor_conditioner.sv */
// self-checking bench for the wheel sensor conditioner
`timescale 1ns/1ps
`default_nettype none
module tb_wheel_sensor_conditioner;
  import wsc_pkg::*;
  localparam int unsigned TMAX_T = 300; // shortened ceiling, above the 200-cycle floor
  localparam int unsigned DIAG_T = 50; // shortened diagnosis run
  // setup words, wave, wait, then interval, rise, fall, feedback, level, step
  typedef struct packed {
    logic [15:0] cfg1, adapt, misc, hi, lo, wt, intv, rise, fall;
    logic fb;
    logic [2:0] lvl, step;
  } wsc_row_t;
  wsc_row_t rows [9] = '{
    '{16'h0001, 16'h0004, 16'h0000, 16'h2580, 16'h0640, 16'h320A, 16'h012C,
      16'h012F, 16'h0003, 1'b1, 3'h2, 3'h2},
    '{16'h0001, 16'h0005, 16'h0000, 16'h0FA0, 16'h0FA0, 16'h258A, 16'h00FA,
      16'h00FD, 16'h0003, 1'b0, 3'h3, 3'h3},
    '{16'h0001, 16'h0004, 16'h0010, 16'h0FA0, 16'h0FA0, 16'h000A, 16'h0000,
      16'h00CB, 16'h0003, 1'b1, 3'h4, 3'h4},
    '{16'h0003, 16'h0084, 16'h0000, 16'h0FA0, 16'h0FA0, 16'h000A, 16'h0000,
      16'h00CB, 16'h0003, 1'b1, 3'h0, 3'h2},
    '{16'h0001, 16'h0006, 16'h0000, 16'h0640, 16'h0640, 16'h1C2A, 16'h00C8,
      16'h00CB, 16'h00CB, 1'b1, 3'h1, 3'h1},
    '{16'h0001, 16'h0007, 16'h0000, 16'h0640, 16'h0640, 16'h000A, 16'h00C8,
      16'h00CB, 16'h00CB, 1'b0, 3'h4, 3'h4},
    '{16'h0001, 16'h0600, 16'h0000, 16'h0640, 16'h0640, 16'h000A, 16'h0000,
      16'h00CB, 16'h0003, 1'b1, 3'h1, 3'h3},
    '{16'h0001, 16'h0024, 16'h0000, 16'h0640, 16'h0640, 16'h000A, 16'h0000,
      16'h00CB, 16'h0003, 1'b1, 3'h4, 3'h0},
    '{16'h0001, 16'h0004, 16'h0000, 16'h0064, 16'h0C1C, 16'h12CA, 16'h0000,
      16'hFFFF, 16'hFFFF, 1'b0, 3'h0, 3'h0}};
  logic [4:0] dg [3] = '{5'h0B, 5'h05, 5'h02}; // fault lines, operative, result
  logic mclk, rst_n, reg_wr, reg_rd, comp_in, sens_open, sens_short_gnd, sens_short_bat;
  logic wheel_out, hyst_fb, diag_active, run, fb;
  logic [3:0] reg_addr, peak_cmp;
  logic [15:0] reg_wdata, reg_rdata, hi_len, lo_len, r, f, d;
  logic [2:0] hyst_step, peak_lvl, fault;
  int miscompares = 0;
  int check_count = 0;
  int n;
  //------------------------------------------------------------
  // design and sensor
  //------------------------------------------------------------
  wsc_conditioner #(.TMAX_CYCLES(TMAX_T), .DIAG_CYCLES(DIAG_T)) dut (
    .mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .comp_in(comp_in),
    .peak_cmp(peak_cmp), .sens_open(sens_open), .sens_short_gnd(sens_short_gnd),
    .sens_short_bat(sens_short_bat), .wheel_out(wheel_out), .hyst_fb(hyst_fb),
    .hyst_step(hyst_step), .diag_active(diag_active));
  wsc_sensor_model sensor (
    .mclk(mclk), .rst_n(rst_n), .run(run), .hi_len(hi_len), .lo_len(lo_len),
    .peak_lvl(peak_lvl), .fault(fault), .comp_in(comp_in), .peak_cmp(peak_cmp),
    .sens_open(sens_open), .sens_short_gnd(sens_short_gnd), .sens_short_bat(sens_short_bat));
  //------------------------------------------------------------
  // tasks
  //------------------------------------------------------------
  // compare and count
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
    end
  endtask
  // one-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  // one-cycle read strobe, data taken in the following cycle
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic rdchk(input logic [3:0] a, input logic [15:0] v);
    rd(a);
    check($sformatf("register %0h", a), d, v);
  endtask
  task automatic step1();
    @(posedge mclk);
    #1;
    n++;
  endtask
  // bounded wait for a comparator level; running out counts a mismatch
  task automatic wait_comp(input logic lvl);
    n = 0;
    while (comp_in !== lvl && n < 20000) step1();
    if (comp_in !== lvl) miscompares++;
  endtask
  // cycles from the next comparator rise and fall to the output edges
  task automatic measure();
    r = 16'hFFFF;
    f = 16'hFFFF;
    fb = 1'b0;
    #1;
    wait_comp(1'b0);
    wait_comp(1'b1);
    n = 0;
    while (wheel_out !== 1'b1 && comp_in === 1'b1 && n < 2000) step1();
    if (wheel_out === 1'b1) begin
      r = n[15:0];
      fb = hyst_fb;
    end
    wait_comp(1'b0);
    n = 0;
    while (wheel_out !== 1'b0 && n < 2000) step1();
    if (r !== 16'hFFFF) f = n[15:0];
  endtask
  task automatic print_verdict();
    if (miscompares == 0 && check_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  //------------------------------------------------------------
  // clock, watchdog and sequence
  //------------------------------------------------------------
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  // cuts a hang short
  initial begin
    repeat (150000) @(posedge mclk);
    miscompares++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    run = 1'b0;
    hi_len = 16'h2580;
    lo_len = 16'h0640;
    peak_lvl = 3'h2;
    fault = 3'h0;
    repeat (10) @(posedge mclk);
    rst_n <= 1'b1;
    rdchk(OFS_CFG_ONE, RST_CFG_ONE);
    rdchk(OFS_ADAPT_SETUP, RST_ADAPT_SETUP);
    rdchk(OFS_MISC_SETUP, RST_MISC_SETUP);
    rdchk(OFS_INTERVAL, 16'(TMAX_T));
    // automatic step 2 from peak level 2 shows in the step field
    rdchk(OFS_STATUS, 16'h0010);
    rdchk(4'hF, 16'h0000);
    wr(OFS_CFG_ONE, 16'h0001);
    rdchk(OFS_INTERVAL, 16'(TMAX_T));
    @(posedge mclk);
    run <= 1'b1;
    // each row rewrites all setup words, so the force bit is cleared after use
    foreach (rows[i]) begin
      wr(OFS_CFG_ONE, rows[i].cfg1);
      wr(OFS_ADAPT_SETUP, rows[i].adapt);
      wr(OFS_MISC_SETUP, rows[i].misc);
      @(posedge mclk);
      hi_len <= rows[i].hi;
      lo_len <= rows[i].lo;
      peak_lvl <= rows[i].lvl;
      repeat (rows[i].wt) @(posedge mclk);
      measure();
      check("rise delay", r, rows[i].rise);
      check("fall delay", f, rows[i].fall);
      check("feedback", fb, rows[i].fb);
      check("hysteresis step", hyst_step, rows[i].step);
      if (rows[i].intv !== 16'h0000) rdchk(OFS_INTERVAL, rows[i].intv);
    end
    // interval sits at the floor now; a fresh enable must bring back the ceiling
    rdchk(OFS_INTERVAL, 16'(TMIN_CYC));
    wr(OFS_CFG_ONE, 16'h0000);
    wr(OFS_CFG_ONE, 16'h0001);
    rdchk(OFS_INTERVAL, 16'(TMAX_T));
    // diagnosis refused in limited mode
    wr(OFS_CFG_ONE, 16'h0003);
    wr(OFS_DIAG_CTRL, 16'h0001);
    repeat (3) @(posedge mclk);
    #1;
    check("limited diagnosis", diag_active, 1'b0);
    wr(OFS_CFG_ONE, 16'h0001);
    @(posedge mclk);
    hi_len <= 16'h0640;
    lo_len <= 16'h0640;
    // each run overwrites the stored result and operative bits
    foreach (dg[i]) begin
      @(posedge mclk);
      fault <= dg[i][4:2];
      repeat (4) @(posedge mclk);
      wr(OFS_DIAG_CTRL, 16'h0001);
      n = 0;
      d = 16'h0000;
      #1;
      while (diag_active === 1'b1 && n < 1000) begin
        if (wheel_out !== 1'b0) d = 16'h0001;
        step1();
      end
      check("diagnosis length", (n >= DIAG_T - 1) && (n <= DIAG_T + 1), 1'b1);
      check("output during diagnosis", d, 16'h0000);
      rd(OFS_STATUS);
      check("diagnosis status", d[2:0], {1'b0, dg[i][1:0]});
    end
    print_verdict();
  end
endmodule
`default_nettype wire

/* wsc_conditioner.sv */
// wheel sensor conditioner: adaptive time filter, hysteresis select and diagnosis
//
// Summary of operation
// - fully adaptive: interval is period over thirty-two
// - rising edge passes after full interval high
// - falling edge passes without delay
// - after falling edge ignore input one interval
// - interval clamped between 4 us and 200 us
// - interval loads maximum after reset
// - enabling the function reloads the interval
// - codes 00/01 pick comparator or filtered feedback
// - code 10 filters falling edges too
// - code 11 filtered feedback plus both-edge filtering
// - fixed-filter bit forces a 4 us interval
// - limited mode select bit, reset zero
// - limited mode uses fixed 4 us interval
// - limited mode keeps hysteresis at or above programmed minimum unless force bit set
// - force bit selects lowest hysteresis step
// - four peak comparators map to five steps
// - manual hysteresis step when automatic is off
// - no diagnosis in limited mode
// - diagnosis tests sensor, output suspended meanwhile
// - diagnosis lasts at least 5 ms
// - diagnosis stores result and operative bits
`timescale 1ns/1ps
`default_nettype none
module wsc_conditioner import wsc_pkg::*; #(
  parameter int unsigned TMAX_CYCLES = TMAX_CYC,
  parameter int unsigned DIAG_CYCLES = DIAG_CYC
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic comp_in,
  input wire logic [3:0] peak_cmp,
  input wire logic sens_open,
  input wire logic sens_short_gnd,
  input wire logic sens_short_bat,
  output logic wheel_out,
  output logic hyst_fb,
  output logic [2:0] hyst_step,
  output logic diag_active
);
  localparam int unsigned DIAG_W = $clog2(DIAG_CYCLES + 1);
  localparam logic [INT_W-1:0] IMAX = INT_W'(TMAX_CYCLES);
  localparam logic [INT_W-1:0] IMIN = INT_W'(TMIN_CYC);
  localparam logic [INT_W-1:0] IFIX = INT_W'(TFIX_CYC);

  //------------------------------------------------------------
  // functions
  //------------------------------------------------------------
  // number of peak comparators tripped
  function automatic logic [2:0] peak_level(input logic [3:0] c);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 4; i++) begin
      n = n + {2'h0, c[i]};
    end
    return n;
  endfunction

  // fixed correlation from peak level to hysteresis step
  function automatic logic [2:0] level_to_step(input logic [2:0] lvl);
    return (lvl > STEP_HIGHEST) ? STEP_HIGHEST : lvl;
  endfunction

  // keep a period-derived interval inside its limits
  function automatic logic [INT_W-1:0] clamp_int(input logic [PER_W-1:0] per);
    logic [PER_W-1:0] s;
    s = per >> PERIOD_SHIFT;
    if (s > PER_W'(IMAX)) begin
      return IMAX;
    end else if (s < PER_W'(IMIN)) begin
      return IMIN;
    end
    return s[INT_W-1:0];
  endfunction

  //------------------------------------------------------------
  // registers
  //------------------------------------------------------------
  logic [15:0] cfg_one_q; // config_word_one
  logic [15:0] adapt_q; // adaptive_setup_word
  logic [15:0] misc_q; // misc_setup_word
  logic diag_result_bit_q; // fault seen by last diagnosis
  logic diag_operative_bit_q; // sensor operative after last diagnosis
  logic diag_busy_q; // diagnosis running
  logic diag_req; // request write strobe
  wsc_cfg_t cfg; // configuration carrier
  logic [INT_W-1:0] interval_q; // adaptive filter interval
  logic wheel_out_q; // filtered output
  logic [2:0] hyst_step_q; // applied hysteresis step
  logic hyst_fb_q; // hysteresis feedback

  assign diag_req = reg_wr && (reg_addr == OFS_DIAG_CTRL) && reg_wdata[B_DIAG_REQ];

  // configuration writes
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_one_q <= RST_CFG_ONE;
      adapt_q <= RST_ADAPT_SETUP;
      misc_q <= RST_MISC_SETUP;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CFG_ONE: cfg_one_q <= reg_wdata;
        OFS_ADAPT_SETUP: adapt_q <= reg_wdata;
        OFS_MISC_SETUP: misc_q <= reg_wdata;
        default: ;
      endcase
    end
  end

  // gather the fields the logic uses
  always_comb begin
    cfg.enable = cfg_one_q[B_ENABLE];
    cfg.limited = cfg_one_q[B_LIMITED];
    cfg.option = adapt_q[B_OPT_LO +: 2];
    cfg.auto_hyst = adapt_q[B_AUTO_HYST];
    cfg.force_min = adapt_q[B_FORCE_MIN];
    cfg.min_step = adapt_q[B_MIN_STEP_LO +: 3];
    cfg.hyst_sel = adapt_q[B_HYST_SEL_LO +: 3];
    cfg.fixed_filt = misc_q[B_FIXED_FILT];
  end

  // read data, valid the cycle after the strobe only
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= '0;
    end else if (reg_rd) begin
      case (reg_addr)
        OFS_CFG_ONE: reg_rdata <= cfg_one_q;
        OFS_ADAPT_SETUP: reg_rdata <= adapt_q;
        OFS_MISC_SETUP: reg_rdata <= misc_q;
        OFS_STATUS: begin
          reg_rdata <= '0;
          reg_rdata[B_DIAG_RESULT] <= diag_result_bit_q;
          reg_rdata[B_DIAG_OPER] <= diag_operative_bit_q;
          reg_rdata[B_DIAG_BUSY] <= diag_busy_q;
          reg_rdata[B_STEP_LO +: 3] <= hyst_step_q;
          reg_rdata[B_OUT] <= wheel_out_q;
        end
        OFS_INTERVAL: reg_rdata <= {{(DATA_W - INT_W){1'b0}}, interval_q};
        default: reg_rdata <= '0; // unmapped reads as zero
      endcase
    end else begin
      reg_rdata <= '0;
    end
  end

  //------------------------------------------------------------
  // input synchronisers
  //------------------------------------------------------------
  logic [7:0] sync1_q; // first stage, read only by second
  logic [7:0] sync2_q; // second stage
  logic comp_d_q; // delayed copy for edge detect
  logic comp_s; // synchronised comparator
  logic [3:0] peak_s; // synchronised peak comparators
  logic enable_d_q; // delayed enable for edge detect

  // two flops on every comparator and fault line input; register bus inputs are not synchronised
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= '0;
      sync2_q <= '0;
    end else begin
      sync1_q <= {sens_short_bat, sens_short_gnd, sens_open, peak_cmp, comp_in};
      sync2_q <= sync1_q;
    end
  end
  assign comp_s = sync2_q[0];
  assign peak_s = sync2_q[4:1];

  // edge detect history
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      comp_d_q <= 1'b0;
      enable_d_q <= 1'b0;
    end else begin
      comp_d_q <= comp_s;
      enable_d_q <= cfg.enable;
    end
  end

  //------------------------------------------------------------
  // period measurement and interval
  //------------------------------------------------------------
  logic [PER_W-1:0] per_q; // clocks since last rising edge
  logic per_valid_q; // one rising edge already seen
  logic rise_edge; // comparator rising edge
  logic en_rise; // function just enabled
  logic [INT_W-1:0] eff_int; // interval in use

  assign rise_edge = comp_s && !comp_d_q;
  assign en_rise = cfg.enable && !enable_d_q;
  assign eff_int = (cfg.limited || cfg.fixed_filt) ? IFIX : interval_q;

  // count clocks between rising edges, saturating
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      per_q <= '0;
      per_valid_q <= 1'b0;
    end else if (en_rise || !cfg.enable) begin
      per_q <= '0;
      per_valid_q <= 1'b0;
    end else if (rise_edge) begin
      per_q <= PER_W'(1);
      per_valid_q <= 1'b1;
    end else if (per_q != '1) begin
      per_q <= per_q + PER_W'(1);
    end
  end

  // next interval from the last period
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      interval_q <= IMAX;
    end else if (en_rise) begin
      interval_q <= IMAX;
    end else if (rise_edge && per_valid_q && !cfg.limited) begin
      interval_q <= clamp_int(per_q);
    end
  end

  //------------------------------------------------------------
  // time filter
  //------------------------------------------------------------
  wsc_state_t st_q; // filter state
  wsc_state_t st_d; // next filter state
  logic out_d; // next output
  logic tmr_load; // restart the interval timer
  logic tmr_exp; // interval elapsed
  logic run; // filter allowed to operate

  assign run = cfg.enable && !diag_busy_q;

  wsc_timer #(
    .W(INT_W)
  ) u_timer (
    .clk(mclk),
    .rst_n(rst_n),
    .load(tmr_load),
    .load_val(eff_int),
    .expire(tmr_exp)
  );

  // next state and output
  always_comb begin
    st_d = st_q;
    out_d = wheel_out_q;
    tmr_load = 1'b0;
    case (st_q)
      ST_LOW: begin
        if (comp_s) begin
          st_d = ST_RISE;
          tmr_load = 1'b1;
        end
      end
      ST_RISE: begin
        if (!comp_s) begin
          st_d = ST_LOW; // short spike dropped
        end else if (tmr_exp) begin
          st_d = ST_HIGH;
          out_d = 1'b1;
        end
      end
      ST_HIGH: begin
        if (!comp_s) begin
          tmr_load = 1'b1;
          if (cfg.option[1]) begin
            st_d = ST_FALL;
          end else begin
            st_d = ST_MASK;
            out_d = 1'b0;
          end
        end
      end
      ST_FALL: begin
        if (comp_s) begin
          st_d = ST_HIGH; // low spike dropped
        end else if (tmr_exp) begin
          st_d = ST_LOW;
          out_d = 1'b0;
        end
      end
      ST_MASK: begin
        if (tmr_exp) begin
          st_d = ST_LOW;
        end
      end
      default: begin
        st_d = ST_LOW;
        out_d = 1'b0;
      end
    endcase
    if (!run) begin
      st_d = ST_LOW;
      out_d = 1'b0;
    end
  end

  // state and output flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_LOW;
      wheel_out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      wheel_out_q <= out_d;
    end
  end

  //------------------------------------------------------------
  // hysteresis selection
  //------------------------------------------------------------
  logic [2:0] step_d; // next hysteresis step

  // automatic, manual, floor and force in that order
  always_comb begin
    step_d = cfg.auto_hyst ? level_to_step(peak_level(peak_s)) : cfg.hyst_sel;
    if (step_d > STEP_HIGHEST) begin
      step_d = STEP_HIGHEST;
    end
    if (cfg.limited && (step_d < cfg.min_step)) begin
      step_d = cfg.min_step;
    end
    if (cfg.force_min) begin
      step_d = STEP_LOWEST;
    end
  end

  // step and feedback flops
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      hyst_step_q <= STEP_LOWEST;
      hyst_fb_q <= 1'b0;
    end else begin
      hyst_step_q <= step_d;
      hyst_fb_q <= cfg.option[0] ? wheel_out_q : comp_s;
    end
  end

  //------------------------------------------------------------
  // diagnosis
  //------------------------------------------------------------
  logic [DIAG_W-1:0] diag_cnt_q; // cycles left in diagnosis

  // run a fixed-length test, then latch result
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_busy_q <= 1'b0;
      diag_cnt_q <= '0;
      diag_result_bit_q <= 1'b0;
      diag_operative_bit_q <= 1'b0;
    end else if (!diag_busy_q) begin
      if (diag_req && !cfg.limited) begin
        diag_busy_q <= 1'b1;
        diag_cnt_q <= DIAG_W'(DIAG_CYCLES);
      end
    end else if (diag_cnt_q == DIAG_W'(1)) begin
      diag_busy_q <= 1'b0;
      diag_cnt_q <= '0;
      diag_result_bit_q <= |sync2_q[7:5];
      diag_operative_bit_q <= !sync2_q[5];
    end else begin
      diag_cnt_q <= diag_cnt_q - DIAG_W'(1);
    end
  end

  assign wheel_out = wheel_out_q;
  assign hyst_fb = hyst_fb_q;
  assign hyst_step = hyst_step_q;
  assign diag_active = diag_busy_q;

  //------------------------------------------------------------
  // assertions
  //------------------------------------------------------------
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_rise_after_wait: assert property ($rose(wheel_out_q) |-> $past(st_q) == ST_RISE &&
    $past(comp_s)) else $error("output rose without a full filter wait");
  a_fall_passes: assert property ((st_q == ST_HIGH) && !comp_s && !cfg.option[1] && run
    |=> !wheel_out_q && st_q == ST_MASK) else $error("falling edge not passed at once");
  a_mask_holds: assert property (st_q == ST_MASK |=> !wheel_out_q)
    else $error("output changed during mask");
  a_interval_range: assert property (interval_q <= IMAX && interval_q >= IMIN)
    else $error("filter interval out of range");
  a_enable_reload: assert property ($rose(cfg.enable) |=> interval_q == IMAX)
    else $error("interval not reloaded on enable");
  a_fixed_interval: assert property (cfg.fixed_filt || cfg.limited |-> eff_int == IFIX)
    else $error("fixed interval not applied");
  a_force_lowest: assert property (cfg.force_min |=> hyst_step_q == STEP_LOWEST)
    else $error("force bit did not select lowest step");
  a_limited_floor: assert property (cfg.limited && !cfg.force_min |=>
    hyst_step_q >= $past(cfg.min_step)) else $error("hysteresis below minimum");
  a_no_diag_limited: assert property (diag_req && cfg.limited && !diag_busy_q
    |=> !diag_busy_q) else $error("diagnosis started in limited mode");
  a_diag_suspends: assert property (diag_busy_q |=> !wheel_out_q)
    else $error("output active during diagnosis");
  a_feedback_src: assert property (##1 hyst_fb_q == ($past(cfg.option[0]) ?
    $past(wheel_out_q) : $past(comp_s))) else $error("wrong feedback source");

  c_pulse_passed: cover property ($fell(wheel_out_q) && st_q == ST_MASK);
  c_both_edges: cover property (st_q == ST_FALL ##1 st_q == ST_LOW);
  c_diag_done: cover property ($fell(diag_busy_q));
  c_interval_update: cover property ($changed(interval_q) && !en_rise);
endmodule
`default_nettype wire

/* wsc_sensor_model.sv */
// stand-in wheel sensor: squared comparator wave, peak levels and fault lines
`timescale 1ns/1ps
`default_nettype none
module wsc_sensor_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [15:0] hi_len,
  input wire logic [15:0] lo_len,
  input wire logic [2:0] peak_lvl,
  input wire logic [2:0] fault,
  output logic comp_in,
  output logic [3:0] peak_cmp,
  output logic sens_open,
  output logic sens_short_gnd,
  output logic sens_short_bat
);
  logic [15:0] left_q; // cycles left in the present level
  //------------------------------------------------------------
  // square wave
  //------------------------------------------------------------
  // low while idle, reloading lo_len each cycle; while running, new lengths are taken only at a level change
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      left_q <= 16'h0000;
      comp_in <= 1'b0;
    end else if (!run) begin
      left_q <= lo_len;
      comp_in <= 1'b0;
    end else if (left_q <= 16'h0001) begin
      left_q <= comp_in ? lo_len : hi_len;
      comp_in <= ~comp_in;
    end else begin
      left_q <= left_q - 16'h0001;
    end
  end
  // four peak comparators as a thermometer code
  assign peak_cmp = 4'hF >> (3'h4 - peak_lvl);
  // fault lines: bit2 battery short, bit1 ground short, bit0 open
  assign {sens_short_bat, sens_short_gnd, sens_open} = fault;
endmodule
`default_nettype wire

/* wsc_timer.sv */
// shared constants and types for the wheel sensor conditioner, plus its interval timer
//------------------------------------------------------------
// package
//------------------------------------------------------------
package wsc_pkg;
  // register bus geometry
  localparam int unsigned ADDR_W = 4;
  localparam int unsigned DATA_W = 16;
  // register offsets
  localparam logic [3:0] OFS_CFG_ONE = 4'h0; // config_word_one
  localparam logic [3:0] OFS_ADAPT_SETUP = 4'h1; // adaptive_setup_word
  localparam logic [3:0] OFS_MISC_SETUP = 4'h2; // misc_setup_word
  localparam logic [3:0] OFS_DIAG_CTRL = 4'h3; // diagnosis request
  localparam logic [3:0] OFS_STATUS = 4'h4; // diagnosis and output state
  localparam logic [3:0] OFS_INTERVAL = 4'h5; // current filter interval
  // config_word_one fields
  localparam int unsigned B_ENABLE = 0;
  localparam int unsigned B_LIMITED = 1;
  // adaptive_setup_word fields
  localparam int unsigned B_OPT_LO = 0;
  localparam int unsigned B_AUTO_HYST = 2;
  localparam int unsigned B_FORCE_MIN = 5;
  localparam int unsigned B_MIN_STEP_LO = 6;
  localparam int unsigned B_HYST_SEL_LO = 9;
  // misc_setup_word fields
  localparam int unsigned B_FIXED_FILT = 4;
  // diagnosis control and status fields
  localparam int unsigned B_DIAG_REQ = 0;
  localparam int unsigned B_DIAG_RESULT = 0;
  localparam int unsigned B_DIAG_OPER = 1;
  localparam int unsigned B_DIAG_BUSY = 2;
  localparam int unsigned B_STEP_LO = 3;
  localparam int unsigned B_OUT = 6;
  // reset values
  localparam logic [15:0] RST_CFG_ONE = 16'h0000;
  localparam logic [15:0] RST_ADAPT_SETUP = 16'h0004;
  localparam logic [15:0] RST_MISC_SETUP = 16'h0000;
  // timing
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned TMAX_FILTER_NS = 200000;
  localparam int unsigned TMIN_FILTER_NS = 4000;
  localparam int unsigned TFIX_FILTER_NS = 4000;
  localparam int unsigned DIAG_TIME_NS = 5000000;
  localparam int unsigned TMAX_CYC = TMAX_FILTER_NS / CLK_PERIOD_NS;
  localparam int unsigned TMIN_CYC = (TMIN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned TFIX_CYC = (TFIX_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned DIAG_CYC = (DIAG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned PERIOD_SHIFT = 5;
  localparam int unsigned INT_W = 14;
  localparam int unsigned PER_W = INT_W + PERIOD_SHIFT;
  // hysteresis steps
  localparam logic [2:0] STEP_LOWEST = 3'h0;
  localparam logic [2:0] STEP_HIGHEST = 3'h4;

  // configuration carrier gathered from the registers
  typedef struct packed {
    logic enable;
    logic limited;
    logic [1:0] option;
    logic auto_hyst;
    logic force_min;
    logic [2:0] min_step;
    logic [2:0] hyst_sel;
    logic fixed_filt;
  } wsc_cfg_t;

  // filter state machine, one-hot
  typedef enum logic [4:0] {
    ST_LOW = 5'b00001,
    ST_RISE = 5'b00010,
    ST_HIGH = 5'b00100,
    ST_FALL = 5'b01000,
    ST_MASK = 5'b10000
  } wsc_state_t;
endpackage

`timescale 1ns/1ps
`default_nettype none
//------------------------------------------------------------
// interval timer
//------------------------------------------------------------
// loaded with n, raises expire in the cycle n-1 edges later
module wsc_timer #(
  parameter int unsigned W = 14
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic expire
);
  logic [W-1:0] cnt_q; // remaining cycles

  // count down to one and hold at zero
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (cnt_q != '0) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

  assign expire = (cnt_q == W'(1)) && !load;
endmodule
`default_nettype wire
